// file: hw/sfdm_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "sfdm_map.svh"

// How it works
// - leaving loss-of-frame sets change-of-LOF flag
// - any change flag drives interrupt pin low
// - in-frame keeps checking every frame's framing bytes
// - in-frame ignores isolated errored frames
// - four errored frames declare SEF from in-frame
// - declared SEF shows in status bit one
// - any SEF change sets change-of-SEF flag
// - SEF-only state tests framing bytes each frame
// - two good frames clear SEF, back in-frame
// - errored frames keep SEF declared
// - SEF held three ms declares loss-of-frame
// - LOF-only exits after programmed good-frame run
// - entering in-frame clears LOF status bit
module sfdm_monitor
  import sfdm_pkg::*;
#(
  parameter int unsigned LOF_CYCLES = `SFDM_SEF_LOF_TIME_US * `SFDM_CLK_MHZ,
  parameter int unsigned TMR_W      = 20
) (
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  input  wire logic [7:0]  line_byte_i,
  input  wire logic        line_valid_i,
  input  wire logic        line_frame_start_i,
  input  wire logic        host_rd_i,
  input  wire logic        host_wr_i,
  input  wire logic [15:0] host_addr_i,
  input  wire logic [7:0]  host_wdata_i,
  output logic      [7:0]  host_rdata_o,
  output logic             int_n_o,
  output logic             sef_defect_o,
  output logic             lof_defect_o
);

  localparam logic [TMR_W-1:0] LOF_LAST = TMR_W'(LOF_CYCLES - 1);

  typedef struct packed {
    sfdm_state_t      state;
    logic [3:0]       err_run;
    logic [3:0]       good_run;
    logic [TMR_W-1:0] timer;
    logic             sef;
    logic             lof;
    logic [7:0]       flags;
    logic [3:0]       thr;
    logic [7:0]       rdata;
    logic             int_n;
  } sfdm_mon_t;

  sfdm_mon_t  r_reg;
  sfdm_mon_t  r_next;
  logic       frame_done;
  logic       frame_err;
  logic       err_frame;
  logic       good_frame;
  logic [3:0] err_cnt;
  logic [3:0] good_cnt;
  logic [3:0] thr_eff;
  logic [7:0] chg_set;
  logic       clear_on_read;

  // saturating run counter step, shared by both runs
  function automatic logic [3:0] sfdm_inc(input logic [3:0] v);
    return (v == 4'hf) ? v : v + 4'h1;
  endfunction

  // ========================================================================
  // framing byte checker
  sfdm_a1a2_check u_check (
    .clk_i         (clk_i),
    .arst_n_i      (arst_n_i),
    .byte_i        (line_byte_i),
    .byte_valid_i  (line_valid_i),
    .frame_start_i (line_frame_start_i),
    .frame_done_o  (frame_done),
    .frame_err_o   (frame_err)
  );

  assign err_frame  = frame_done & frame_err;
  assign good_frame = frame_done & ~frame_err;
  assign err_cnt    = sfdm_inc(r_reg.err_run);
  assign good_cnt   = sfdm_inc(r_reg.good_run);
  // a threshold of zero would mean no test at all; treat it as one frame
  assign thr_eff    = (r_reg.thr == 4'h0) ? 4'h1 : r_reg.thr;
  assign clear_on_read = host_rd_i && (host_addr_i == `SFDM_ADDR_FLAGS);

  // ========================================================================
  // alignment state machine, defect bits, change flags and register port
  always_comb begin
    r_next  = r_reg;
    chg_set = 8'h00;
    // consecutive-frame runs; one good frame breaks an error run and back
    if (err_frame) begin
      r_next.err_run  = err_cnt;
      r_next.good_run = 4'h0;
    end else if (good_frame) begin
      r_next.good_run = good_cnt;
      r_next.err_run  = 4'h0;
    end
    r_next.timer = (r_reg.state == SFDM_SEF1_LOF0) ? r_reg.timer + TMR_W'(1) : '0;

    unique case (r_reg.state)
      SFDM_IN_FRAME: begin
        if (err_frame && err_cnt >= `SFDM_ERR_FRAMES) begin
          r_next.state = SFDM_SEF1_LOF0;
        end
      end
      SFDM_SEF1_LOF0: begin
        // recovery wins over the timeout when both fall in one cycle
        if (good_frame && good_cnt >= `SFDM_GOOD_FRAMES) begin
          r_next.state = SFDM_IN_FRAME;
        end else if (r_reg.timer >= LOF_LAST) begin
          r_next.state = SFDM_SEF1_LOF1;
        end
      end
      SFDM_SEF1_LOF1: begin
        if (good_frame && good_cnt >= `SFDM_GOOD_FRAMES) begin
          r_next.state = SFDM_SEF0_LOF1;
        end
      end
      SFDM_SEF0_LOF1: begin
        if (good_frame && good_cnt >= thr_eff) begin
          r_next.state = SFDM_IN_FRAME;
        end else if (err_frame && err_cnt >= `SFDM_ERR_FRAMES) begin
          r_next.state = SFDM_SEF1_LOF1;
        end
      end
    endcase

    // every transition starts fresh runs
    if (r_next.state != r_reg.state) begin
      r_next.err_run  = 4'h0;
      r_next.good_run = 4'h0;
    end

    // defect bits follow the state; SEF stays up while errors keep coming
    r_next.sef = (r_next.state == SFDM_SEF1_LOF0) ||
                 (r_next.state == SFDM_SEF1_LOF1);
    r_next.lof = (r_next.state == SFDM_SEF1_LOF1) ||
                 (r_next.state == SFDM_SEF0_LOF1);

    chg_set[`SFDM_BIT_SEF] = r_next.sef != r_reg.sef;
    chg_set[`SFDM_BIT_LOF] = r_next.lof != r_reg.lof;

    // a change arriving during the clearing read is kept
    r_next.flags = (clear_on_read ? 8'h00 : r_reg.flags) | chg_set;
    r_next.int_n = ~|r_next.flags;

    if (host_wr_i && host_addr_i == `SFDM_ADDR_THRESH) begin
      r_next.thr = host_wdata_i[3:0];
    end

    // read data lands one cycle after the strobe; flags show pre-clear value
    if (host_rd_i) begin
      unique case (host_addr_i)
        `SFDM_ADDR_STATUS: begin
          r_next.rdata = 8'h00;
          r_next.rdata[`SFDM_BIT_SEF] = r_reg.sef;
          r_next.rdata[`SFDM_BIT_LOF] = r_reg.lof;
        end
        `SFDM_ADDR_FLAGS:  r_next.rdata = r_reg.flags;
        `SFDM_ADDR_THRESH: r_next.rdata = {4'h0, r_reg.thr};
        default:           r_next.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      r_reg       <= '0;
      r_reg.state <= SFDM_IN_FRAME;
      r_reg.thr   <= `SFDM_THR_RST;
      r_reg.int_n <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign host_rdata_o = r_reg.rdata;
  assign int_n_o      = r_reg.int_n;
  assign sef_defect_o = r_reg.sef;
  assign lof_defect_o = r_reg.lof;

  // ========================================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  a_lof_leave_flag: assert property ($fell(r_reg.lof) |-> r_reg.flags[`SFDM_BIT_LOF])
    else $error("change-of-LOF flag not set on leaving LOF");
  a_int_pin_low: assert property ($rose(|r_reg.flags) |-> !int_n_o)
    else $error("interrupt pin not low with a flag pending");
  a_err_run_count: assert property (
    (r_reg.state == SFDM_IN_FRAME && err_frame && r_reg.err_run == 4'h1)
      |=> r_reg.err_run == 4'h2)
    else $error("in-frame error run not counted");
  a_isolated_err_ok: assert property (
    (r_reg.state == SFDM_IN_FRAME && err_frame && r_reg.err_run == 4'h0)
      |=> r_reg.state == SFDM_IN_FRAME && !r_reg.sef)
    else $error("isolated errored frame left in-frame");
  a_sef_declare: assert property (
    (r_reg.state == SFDM_IN_FRAME && err_frame && r_reg.err_run == 4'h3)
      |=> r_reg.state == SFDM_SEF1_LOF0)
    else $error("fourth errored frame did not declare SEF");
  a_sef_status_bit: assert property (
    r_reg.state == SFDM_SEF1_LOF0 |-> r_reg.sef && !r_reg.lof)
    else $error("SEF-only state shows wrong defect bits");
  a_sef_chg_flag: assert property ($changed(r_reg.sef) |-> r_reg.flags[`SFDM_BIT_SEF])
    else $error("change-of-SEF flag not set");
  a_sef_recover: assert property (
    (r_reg.state == SFDM_SEF1_LOF0 && good_frame && r_reg.good_run == 4'h1)
      |=> r_reg.state == SFDM_IN_FRAME && !r_reg.sef)
    else $error("two good frames did not clear SEF");
  a_sef_hold: assert property (
    (r_reg.state == SFDM_SEF1_LOF0 && err_frame) |=> r_reg.sef)
    else $error("SEF dropped while errors continue");
  a_lof_timeout: assert property (
    (r_reg.state == SFDM_SEF1_LOF0 && r_reg.timer == LOF_LAST &&
     !(good_frame && r_reg.good_run == 4'h1)) |=> r_reg.state == SFDM_SEF1_LOF1 && r_reg.lof)
    else $error("SEF held for the timeout did not declare LOF");
  a_lof_short_run: assert property (
    (r_reg.state == SFDM_SEF0_LOF1 && good_frame && good_cnt < thr_eff)
      |=> r_reg.state == SFDM_SEF0_LOF1)
    else $error("LOF left before the in-sync run");
  a_lof_clear_bit: assert property (
    (r_reg.state == SFDM_SEF0_LOF1 && good_frame && good_cnt >= thr_eff)
      |=> !r_reg.lof ##1 !r_reg.lof || r_reg.state != SFDM_IN_FRAME)
    else $error("LOF bit not cleared on reaching in-frame");
  a_read_clears: assert property (
    (clear_on_read && chg_set == 8'h00) |=> r_reg.flags == 8'h00 && int_n_o)
    else $error("flag read did not clear flags and release pin");

  c_sef_entered: cover property (r_reg.state == SFDM_IN_FRAME ##1 r_reg.state == SFDM_SEF1_LOF0);
  c_lof_entered: cover property ($rose(r_reg.lof));
  c_lof_recovered: cover property (r_reg.state == SFDM_SEF0_LOF1 ##1 r_reg.state == SFDM_IN_FRAME);
  c_int_cleared: cover property (!int_n_o ##1 clear_on_read ##1 int_n_o);

endmodule
`default_nettype wire

// file: hw/sfdm_map.svh
`ifndef SFDM_MAP_SVH
`define SFDM_MAP_SVH

// ==========================================================================
// register map
`define SFDM_ADDR_STATUS     16'h1107
`define SFDM_ADDR_FLAGS      16'h110b
`define SFDM_ADDR_THRESH     16'h112b
`define SFDM_BIT_SEF         1
`define SFDM_BIT_LOF         2
`define SFDM_THR_RST         4'h8

// ==========================================================================
// framing pattern and alignment criteria
`define SFDM_A1              8'hf6
`define SFDM_A2              8'h28
`define SFDM_A1_COUNT        3
`define SFDM_A2_COUNT        3
`define SFDM_ERR_FRAMES      4'h4
`define SFDM_GOOD_FRAMES     4'h2

// ==========================================================================
// timing
`define SFDM_SEF_LOF_TIME_US 3000
`define SFDM_CLK_MHZ         200

`endif

// file: hw/sfdm_pkg.sv
package sfdm_pkg;

  // ========================================================================
  // alignment states
  typedef enum logic [1:0] {
    SFDM_IN_FRAME,
    SFDM_SEF1_LOF0,
    SFDM_SEF1_LOF1,
    SFDM_SEF0_LOF1
  } sfdm_state_t;

  // ========================================================================
  // framing byte checker state
  typedef struct packed {
    logic [3:0] pos;
    logic       err;
    logic       done;
    logic       ferr;
  } sfdm_chk_t;

endpackage

// file: hw/sfdm_a1a2_check.sv
`timescale 1ns/1ps
`default_nettype none
`include "sfdm_map.svh"

module sfdm_a1a2_check
  import sfdm_pkg::*;
#(
  parameter int unsigned A1_COUNT = `SFDM_A1_COUNT,
  parameter int unsigned A2_COUNT = `SFDM_A2_COUNT
) (
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  input  wire logic [7:0] byte_i,
  input  wire logic       byte_valid_i,
  input  wire logic       frame_start_i,
  output logic            frame_done_o,
  output logic            frame_err_o
);

  localparam logic [3:0] LAST_POS = 4'(A1_COUNT + A2_COUNT - 1);
  localparam logic [3:0] A1_END   = 4'(A1_COUNT);

  sfdm_chk_t r_reg;
  sfdm_chk_t r_next;

  // ========================================================================
  // walk the framing bytes of each frame; one verdict pulse per frame
  always_comb begin
    r_next      = r_reg;
    r_next.done = 1'b0;
    if (byte_valid_i) begin
      if (frame_start_i) begin
        // a new frame start restarts the check, even mid-pattern
        r_next.pos = 4'h1;
        r_next.err = (byte_i != `SFDM_A1);
      end else if (r_reg.pos != 4'h0) begin
        r_next.err = r_reg.err | (byte_i != ((r_reg.pos < A1_END) ? `SFDM_A1 : `SFDM_A2));
        if (r_reg.pos == LAST_POS) begin
          r_next.pos  = 4'h0;
          r_next.done = 1'b1;
          r_next.ferr = r_next.err;
        end else begin
          r_next.pos = r_reg.pos + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign frame_done_o = r_reg.done;
  assign frame_err_o  = r_reg.ferr;

endmodule
`default_nettype wire

// file: hw/unused_placeholder_never.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// file: tb/sfdm_line_src.sv
`timescale 1ns/1ps
`default_nettype none
`include "sfdm_map.svh"

// ==========================================================================
// line side model: sends one frame's framing bytes, then idles
module sfdm_line_src (
  input  wire logic       clk_i,
  output logic      [7:0] byte_o,
  output logic            valid_o,
  output logic            start_o
);
  initial begin
    byte_o  = 8'h00;
    valid_o = 1'b0;
    start_o = 1'b0;
  end

  // three A1 then three A2; a bad frame spoils only the last A2 byte
  // idle bytes flip every cycle, so every second one repeats the frame's last byte
  task automatic send(input logic good);
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_i);
      #1;
      valid_o = (i < 6);
      start_o = (i == 0);
      byte_o  = ((i < 3) ? `SFDM_A1 : (i < 6) ? `SFDM_A2 : ~byte_o)
                ^ {7'h00, (i == 5) && !good};
    end
  endtask
endmodule
`default_nettype wire

// file: tb/sonet_frame_defect_monitor_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "sfdm_map.svh"

module sonet_frame_defect_monitor_test;
  // ========================================================================
  // signals
  logic        clk_i;
  logic        arst_n_i;
  logic [7:0]  line_byte;
  logic        line_valid;
  logic        line_start;
  logic        host_rd_i;
  logic        host_wr_i;
  logic [15:0] host_addr_i;
  logic [7:0]  host_wdata_i;
  logic [7:0]  host_rdata_o;
  logic        int_n_o;
  logic        sef_defect_o;
  logic        lof_defect_o;
  int          bad_count;
  int          samples_checked;

  // short loss-of-frame time keeps the run brief; frames last 10 cycles
  sfdm_monitor #(.LOF_CYCLES(50), .TMR_W(20)) DUT (
    .clk_i              (clk_i),
    .arst_n_i           (arst_n_i),
    .line_byte_i        (line_byte),
    .line_valid_i       (line_valid),
    .line_frame_start_i (line_start),
    .host_rd_i          (host_rd_i),
    .host_wr_i          (host_wr_i),
    .host_addr_i        (host_addr_i),
    .host_wdata_i       (host_wdata_i),
    .host_rdata_o       (host_rdata_o),
    .int_n_o            (int_n_o),
    .sef_defect_o       (sef_defect_o),
    .lof_defect_o       (lof_defect_o)
  );

  sfdm_line_src SRC (
    .clk_i   (clk_i),
    .byte_o  (line_byte),
    .valid_o (line_valid),
    .start_o (line_start)
  );

  // ========================================================================
  // host access and checking
  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask

  // one-cycle strobe; read data is settled just after the edge that takes it
  task automatic rchk(input string n, input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    #1;
    host_rd_i   = 1'b1;
    host_addr_i = a;
    @(posedge clk_i);
    #1;
    host_rd_i = 1'b0;
    chk(n, host_rdata_o, exp);
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    host_wr_i    = 1'b1;
    host_addr_i  = a;
    host_wdata_i = d;
    @(posedge clk_i);
    #1;
    host_wr_i = 1'b0;
  endtask

  task automatic frames(input logic good, input int n);
    repeat (n) SRC.send(good);
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ========================================================================
  // clock, reset and watchdog
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    finish_test();
  end

  // ========================================================================
  // main sequence
  initial begin
    bad_count       = 0;
    samples_checked = 0;
    host_rd_i       = 1'b0;
    host_wr_i       = 1'b0;
    host_addr_i     = 16'h0000;
    host_wdata_i    = 8'h00;
    arst_n_i        = 1'b0;
    repeat (12) @(posedge clk_i);
    #1;
    arst_n_i = 1'b1;
    rchk("status", `SFDM_ADDR_STATUS, 8'h00);
    rchk("thresh", `SFDM_ADDR_THRESH, 8'h08);
    rchk("unmapped", 16'h1100, 8'h00);
    chk("int_n", {7'h00, int_n_o}, 8'h01);
    // errored runs broken by a good frame never declare the defect
    frames(1'b0, 3);
    frames(1'b1, 1);
    frames(1'b0, 3);
    rchk("status", `SFDM_ADDR_STATUS, 8'h00);
    frames(1'b0, 1);
    rchk("status", `SFDM_ADDR_STATUS, 8'h02);
    chk("sef_defect", {7'h00, sef_defect_o}, 8'h01);
    chk("lof_defect", {7'h00, lof_defect_o}, 8'h00);
    chk("int_n", {7'h00, int_n_o}, 8'h00);
    rchk("flags", `SFDM_ADDR_FLAGS, 8'h02);
    rchk("flags", `SFDM_ADDR_FLAGS, 8'h00);
    chk("int_n", {7'h00, int_n_o}, 8'h01);
    frames(1'b1, 2);
    rchk("status", `SFDM_ADDR_STATUS, 8'h00);
    chk("sef_defect", {7'h00, sef_defect_o}, 8'h00);
    rchk("flags", `SFDM_ADDR_FLAGS, 8'h02);
    // errored frames outlast the loss-of-frame time
    frames(1'b0, 4);
    frames(1'b0, 6);
    rchk("status", `SFDM_ADDR_STATUS, 8'h06);
    chk("lof_defect", {7'h00, lof_defect_o}, 8'h01);
    rchk("flags", `SFDM_ADDR_FLAGS, 8'h06);
    wr(`SFDM_ADDR_THRESH, 8'hf3);
    rchk("thresh", `SFDM_ADDR_THRESH, 8'h03);
    frames(1'b1, 2);
    rchk("status", `SFDM_ADDR_STATUS, 8'h04);
    rchk("flags", `SFDM_ADDR_FLAGS, 8'h02);
    // one short of the threshold keeps loss-of-frame
    frames(1'b1, 2);
    rchk("status", `SFDM_ADDR_STATUS, 8'h04);
    frames(1'b1, 1);
    rchk("status", `SFDM_ADDR_STATUS, 8'h00);
    chk("lof_defect", {7'h00, lof_defect_o}, 8'h00);
    chk("int_n", {7'h00, int_n_o}, 8'h00);
    rchk("flags", `SFDM_ADDR_FLAGS, 8'h04);
    // status is read-only
    wr(`SFDM_ADDR_STATUS, 8'hff);
    rchk("status", `SFDM_ADDR_STATUS, 8'h00);
    // back into loss-of-frame; errors during the in-sync test raise SEF again
    frames(1'b0, 10);
    rchk("status", `SFDM_ADDR_STATUS, 8'h06);
    rchk("flags", `SFDM_ADDR_FLAGS, 8'h06);
    frames(1'b1, 2);
    rchk("status", `SFDM_ADDR_STATUS, 8'h04);
    frames(1'b0, 4);
    rchk("status", `SFDM_ADDR_STATUS, 8'h06);
    chk("sef_defect", {7'h00, sef_defect_o}, 8'h01);
    rchk("flags", `SFDM_ADDR_FLAGS, 8'h02);
    // a zero threshold still needs one good frame
    wr(`SFDM_ADDR_THRESH, 8'h00);
    rchk("thresh", `SFDM_ADDR_THRESH, 8'h00);
    frames(1'b1, 2);
    rchk("status", `SFDM_ADDR_STATUS, 8'h04);
    frames(1'b1, 1);
    rchk("status", `SFDM_ADDR_STATUS, 8'h00);
    rchk("flags", `SFDM_ADDR_FLAGS, 8'h06);
    // a mid-run reset with SEF pending returns everything to idle
    frames(1'b0, 4);
    chk("int_n", {7'h00, int_n_o}, 8'h00);
    @(posedge clk_i);
    #1;
    arst_n_i = 1'b0;
    repeat (12) @(posedge clk_i);
    #1;
    arst_n_i = 1'b1;
    chk("sef_defect", {7'h00, sef_defect_o}, 8'h00);
    chk("int_n", {7'h00, int_n_o}, 8'h01);
    rchk("status", `SFDM_ADDR_STATUS, 8'h00);
    rchk("flags", `SFDM_ADDR_FLAGS, 8'h00);
    rchk("thresh", `SFDM_ADDR_THRESH, 8'h08);
    finish_test();
  end
endmodule
`default_nettype wire
